// ---- rtl/mpr_pkg.sv ----
package mpr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [4:0] ADDR_ELECTRICAL_POSITION = 5'h02;
  localparam logic [4:0] ADDR_MARKED_POSITION     = 5'h03;
  localparam logic [4:0] ADDR_CURRENT_SPEED       = 5'h04;
  localparam logic [4:0] ADDR_ACCEL_RATE          = 5'h05;
  localparam logic [4:0] ADDR_DECEL_RATE          = 5'h06;
  localparam logic [4:0] ADDR_SPEED_CEILING       = 5'h07;
  localparam logic [4:0] ADDR_SPEED_FLOOR         = 5'h08;
  localparam logic [4:0] ADDR_HOLD_CURRENT        = 5'h09;
  localparam logic [4:0] ADDR_RUN_CURRENT         = 5'h0a;
  localparam logic [4:0] ADDR_ACCEL_CURRENT       = 5'h0b;
  localparam logic [4:0] ADDR_DECEL_CURRENT       = 5'h0c;
  localparam logic [4:0] ADDR_DECAY_FALL_TIMES    = 5'h0e;
  localparam logic [4:0] ADDR_MIN_ON_TIME         = 5'h0f;
  localparam logic [4:0] ADDR_FULLSTEP_THRESHOLD  = 5'h15;
  localparam logic [4:0] ADDR_STATUS              = 5'h19;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [8:0]  RST_ELECTRICAL_POSITION = 9'h000;
  localparam logic [21:0] RST_MARKED_POSITION     = 22'h000000;
  localparam logic [11:0] RST_ACCEL_RATE          = 12'h08a;
  localparam logic [11:0] RST_DECEL_RATE          = 12'h08a;
  localparam logic [9:0]  RST_SPEED_CEILING       = 10'h041;
  localparam logic [12:0] RST_SPEED_FLOOR         = 13'h0000;
  localparam logic [9:0]  RST_FULLSTEP_THRESHOLD  = 10'h027;
  localparam logic [6:0]  RST_CURRENT_LEVEL       = 7'h29;
  localparam logic [7:0]  RST_DECAY_FALL_TIMES    = 8'h19;
  localparam logic [6:0]  RST_MIN_ON_TIME         = 7'h29;

  // ****************************************************************
  // Field layouts and special codes
  // ****************************************************************
  localparam int          EP_STEP_LSB       = 7;
  localparam int          FLOOR_MSB         = 11;
  localparam int          DECAY_LSB         = 4;
  localparam logic [11:0] ACCEL_INFINITE    = 12'hfff;
  localparam logic [9:0]  FULLSTEP_NEVER    = 10'h0ff;
  // Speed ceiling/threshold are 0.18, current speed is 0.28
  localparam int          SPEED_ALIGN_SHIFT = 10;
  localparam logic [19:0] HALF_LSB_0P18     = 20'h00200;
  localparam int          NOTPERF_BIT       = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYS_CLK_MHZ   = 40;
  localparam int TICK_NS       = 250;
  localparam int TICK_CYCLES   = TICK_NS * SYS_CLK_MHZ / 1000;
  localparam int HALF_US_NS    = 500;
  localparam int HALF_US_CYCLES = HALF_US_NS * SYS_CLK_MHZ / 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    MPR_STOPPED = 4'b0001,
    MPR_ACCEL   = 4'b0010,
    MPR_CONST   = 4'b0100,
    MPR_DECEL   = 4'b1000
  } mpr_motion_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [21:0] wdata;
  } mpr_access_t;

  typedef struct packed {
    logic [6:0]  torque_level;
    logic [8:0]  electrical_position;
    logic        infinite_accel;
    logic [11:0] ramp_accel;
    logic [11:0] ramp_decel;
    logic        fullstep_active;
    logic [3:0]  max_fast_decay_time;
    logic [3:0]  max_fall_step_time;
    logic [6:0]  min_on_time;
  } mpr_control_t;

endpackage

// ---- rtl/mpr_regs.sv ----
`timescale 1ns/1ps

// Operation
// - Electrical position: two MSBs are full step, seven LSBs microstep in 1/128.
// - Written electrical position reaches the control output two cycles after the write.
// - Stop-only registers ignore writes while running and raise not-performed flag.
// - Mark holds a 22-bit two's complement position.
// - Current speed is unsigned 0.28 steps per 250 ns tick.
// - Writes to current speed always rejected and raise not-performed flag.
// - Acceleration and deceleration are unsigned 0.40 steps per tick squared.
// - All-ones acceleration selects infinite acceleration mode.
// - Infinite acceleration ignores the deceleration register.
// - Maximum speed is unsigned 0.18 steps per tick.
// - Minimum speed uses bits 11..0 at 2^-24, bit 12 reads zero.
// - Minimum speed write while running raises not-performed flag.
// - Above threshold plus half LSB, switch to two-phase-on full stepping.
// - Threshold code 0x0ff keeps microstepping at all speeds.
// - Zero threshold is a real low threshold, not full-step mode.
// - Torque level from hold, run, accel or decel register by motion state.
// - Torque code n means (n+1) times 31.25 mA, passed on unchanged.
// - Decay/fall register: fast decay bits 7..4, fall step bits 3..0.
// - Minimum on time is a 7-bit code in half microsecond steps.
// - Stop-writable only when stopped, high-impedance-writable only at high impedance.
module mpr_regs (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire mpr_pkg::mpr_access_t  access,
  output logic [21:0]                rdata,
  input  wire mpr_pkg::mpr_motion_t  motion,
  input  wire logic                  outputs_hiz,
  input  wire logic [19:0]           speed_in,
  input  wire logic                  electrical_position_advance,
  input  wire logic [8:0]            electrical_position_next,
  input  wire logic [6:0]            status_other,
  output mpr_pkg::mpr_control_t      control,
  output logic [21:0]                marked_position,
  output logic [9:0]                 speed_ceiling,
  output logic [12:0]                speed_floor
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [8:0]  electrical_position;
  logic [19:0] current_speed;
  logic [11:0] accel_rate;
  logic [11:0] decel_rate;
  logic [9:0]  fullstep_switch_threshold;
  logic [6:0]  hold_current_level;
  logic [6:0]  run_current_level;
  logic [6:0]  accel_current_level;
  logic [6:0]  decel_current_level;
  logic [7:0]  decay_fall_times;
  logic [6:0]  min_on_time;
  logic        command_not_performed_flag;
  logic        running;
  logic        stop_writable;
  logic        hiz_writable;
  logic        wr_rejected;
  logic [19:0] threshold_0p28;
  logic [6:0]  next_torque;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = a == target;
  endfunction

  // ****************************************************************
  // Write qualification
  // ****************************************************************
  assign running       = motion != mpr_pkg::MPR_STOPPED;
  assign stop_writable = !running;
  assign hiz_writable  = outputs_hiz;

  always_comb begin
    wr_rejected = 1'b0;
    if (access.wr) begin
      case (access.addr)
        mpr_pkg::ADDR_ELECTRICAL_POSITION,
        mpr_pkg::ADDR_ACCEL_RATE,
        mpr_pkg::ADDR_DECEL_RATE,
        mpr_pkg::ADDR_SPEED_FLOOR: wr_rejected = !stop_writable;
        mpr_pkg::ADDR_DECAY_FALL_TIMES,
        mpr_pkg::ADDR_MIN_ON_TIME: wr_rejected = !stop_writable || !hiz_writable;
        mpr_pkg::ADDR_CURRENT_SPEED: wr_rejected = 1'b1;
        default: wr_rejected = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Not-performed flag
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      command_not_performed_flag <= 1'b0;
    end else if (wr_rejected) begin
      command_not_performed_flag <= 1'b1;
    end else if (access.rd && hit(access.addr, mpr_pkg::ADDR_STATUS)) begin
      command_not_performed_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Electrical position
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      electrical_position <= mpr_pkg::RST_ELECTRICAL_POSITION;
    end else if (access.wr && hit(access.addr, mpr_pkg::ADDR_ELECTRICAL_POSITION)
                 && !wr_rejected) begin
      electrical_position <= access.wdata[8:0];
    end else if (electrical_position_advance) begin
      electrical_position <= electrical_position_next;
    end
  end

  // ****************************************************************
  // Speed capture, read only
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      current_speed <= 20'h00000;
    end else begin
      current_speed <= speed_in;
    end
  end

  // ****************************************************************
  // Profile registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      marked_position           <= mpr_pkg::RST_MARKED_POSITION;
      accel_rate                <= mpr_pkg::RST_ACCEL_RATE;
      decel_rate                <= mpr_pkg::RST_DECEL_RATE;
      speed_ceiling             <= mpr_pkg::RST_SPEED_CEILING;
      speed_floor               <= mpr_pkg::RST_SPEED_FLOOR;
      fullstep_switch_threshold <= mpr_pkg::RST_FULLSTEP_THRESHOLD;
    end else if (access.wr && !wr_rejected) begin
      case (access.addr)
        mpr_pkg::ADDR_MARKED_POSITION: marked_position <= access.wdata;
        mpr_pkg::ADDR_ACCEL_RATE: accel_rate <= access.wdata[11:0];
        mpr_pkg::ADDR_DECEL_RATE: decel_rate <= access.wdata[11:0];
        mpr_pkg::ADDR_SPEED_CEILING: speed_ceiling <= access.wdata[9:0];
        mpr_pkg::ADDR_SPEED_FLOOR: begin
          speed_floor <= {1'b0, access.wdata[mpr_pkg::FLOOR_MSB:0]};
        end
        mpr_pkg::ADDR_FULLSTEP_THRESHOLD: begin
          fullstep_switch_threshold <= access.wdata[9:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Current control registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_current_level  <= mpr_pkg::RST_CURRENT_LEVEL;
      run_current_level   <= mpr_pkg::RST_CURRENT_LEVEL;
      accel_current_level <= mpr_pkg::RST_CURRENT_LEVEL;
      decel_current_level <= mpr_pkg::RST_CURRENT_LEVEL;
      decay_fall_times    <= mpr_pkg::RST_DECAY_FALL_TIMES;
      min_on_time         <= mpr_pkg::RST_MIN_ON_TIME;
    end else if (access.wr && !wr_rejected) begin
      case (access.addr)
        mpr_pkg::ADDR_HOLD_CURRENT: hold_current_level <= access.wdata[6:0];
        mpr_pkg::ADDR_RUN_CURRENT: run_current_level <= access.wdata[6:0];
        mpr_pkg::ADDR_ACCEL_CURRENT: accel_current_level <= access.wdata[6:0];
        mpr_pkg::ADDR_DECEL_CURRENT: decel_current_level <= access.wdata[6:0];
        mpr_pkg::ADDR_DECAY_FALL_TIMES: decay_fall_times <= access.wdata[7:0];
        mpr_pkg::ADDR_MIN_ON_TIME: min_on_time <= access.wdata[6:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Derived control
  // ****************************************************************
  // Threshold aligned to 0.28 with the half LSB added
  assign threshold_0p28 = {fullstep_switch_threshold, 10'h000} + mpr_pkg::HALF_LSB_0P18;

  always_comb begin
    case (motion)
      mpr_pkg::MPR_STOPPED: next_torque = hold_current_level;
      mpr_pkg::MPR_ACCEL:   next_torque = accel_current_level;
      mpr_pkg::MPR_CONST:   next_torque = run_current_level;
      mpr_pkg::MPR_DECEL:   next_torque = decel_current_level;
      default:              next_torque = hold_current_level;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      control <= '0;
    end else begin
      control.torque_level        <= next_torque;
      control.electrical_position <= electrical_position;
      control.infinite_accel      <= accel_rate == mpr_pkg::ACCEL_INFINITE;
      control.ramp_accel          <= accel_rate;
      // Deceleration follows acceleration in infinite mode
      control.ramp_decel          <= (accel_rate == mpr_pkg::ACCEL_INFINITE) ?
                                     accel_rate : decel_rate;
      control.fullstep_active     <= (fullstep_switch_threshold != mpr_pkg::FULLSTEP_NEVER)
                                     && (current_speed > threshold_0p28);
      control.max_fast_decay_time <= decay_fall_times[7:mpr_pkg::DECAY_LSB];
      control.max_fall_step_time  <= decay_fall_times[mpr_pkg::DECAY_LSB-1:0];
      control.min_on_time         <= min_on_time;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= 22'h000000;
    end else if (access.rd) begin
      case (access.addr)
        mpr_pkg::ADDR_ELECTRICAL_POSITION: rdata <= {13'h0000, electrical_position};
        mpr_pkg::ADDR_MARKED_POSITION:     rdata <= marked_position;
        mpr_pkg::ADDR_CURRENT_SPEED:       rdata <= {2'h0, current_speed};
        mpr_pkg::ADDR_ACCEL_RATE:          rdata <= {10'h000, accel_rate};
        mpr_pkg::ADDR_DECEL_RATE:          rdata <= {10'h000, decel_rate};
        mpr_pkg::ADDR_SPEED_CEILING:       rdata <= {12'h000, speed_ceiling};
        mpr_pkg::ADDR_SPEED_FLOOR:         rdata <= {9'h000, speed_floor};
        mpr_pkg::ADDR_FULLSTEP_THRESHOLD:  rdata <= {12'h000, fullstep_switch_threshold};
        mpr_pkg::ADDR_HOLD_CURRENT:        rdata <= {15'h0000, hold_current_level};
        mpr_pkg::ADDR_RUN_CURRENT:         rdata <= {15'h0000, run_current_level};
        mpr_pkg::ADDR_ACCEL_CURRENT:       rdata <= {15'h0000, accel_current_level};
        mpr_pkg::ADDR_DECEL_CURRENT:       rdata <= {15'h0000, decel_current_level};
        mpr_pkg::ADDR_DECAY_FALL_TIMES:    rdata <= {14'h0000, decay_fall_times};
        mpr_pkg::ADDR_MIN_ON_TIME:         rdata <= {15'h0000, min_on_time};
        mpr_pkg::ADDR_STATUS: begin
          rdata <= {14'h0000, command_not_performed_flag, status_other};
        end
        default:                           rdata <= 22'h000000;
      endcase
    end
  end

endmodule

// ---- testbench/mpr_regs_chk.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Register bank checker
// ****************************************************************
module mpr_regs_chk (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire mpr_pkg::mpr_access_t  access,
  input  wire logic [21:0]           rdata,
  input  wire mpr_pkg::mpr_motion_t  motion,
  input  wire logic                  outputs_hiz,
  input  wire mpr_pkg::mpr_control_t control,
  input  wire logic [21:0]           marked_position,
  input  wire logic [12:0]           speed_floor
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic run;
  logic refused;
  logic flag;
  assign run = motion != mpr_pkg::MPR_STOPPED;
  assign refused = access.wr && (access.addr == 5'h04
      || (run && access.addr inside {5'h02, 5'h05, 5'h06, 5'h08})
      || ((run || !outputs_hiz) && access.addr inside {5'h0e, 5'h0f}));
  // Expected not-performed flag
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (refused) begin
      flag <= 1'b1;
    end else if (access.rd && access.addr == 5'h19) begin
      flag <= 1'b0;
    end
  end
  sequence s_wr(a);
    access.wr && access.addr == a;
  endsequence
  AST_FLAG_READ: assert property (access.rd && access.addr == 5'h19 |=>
      rdata[7] == $past(flag)) else $error("status flag wrong");
  AST_EP_WRITE: assert property (s_wr(5'h02) ##0 !run |-> ##2
      control.electrical_position == $past(access.wdata[8:0], 2)) else $error("electrical_position late");
  AST_ACC_HELD: assert property (s_wr(5'h05) ##0 run |-> ##2
      $stable(control.ramp_accel)) else $error("accel changed while running");
  AST_INF_ACCEL: assert property (control.infinite_accel ==
      (control.ramp_accel == mpr_pkg::ACCEL_INFINITE)) else $error("infinite mode wrong");
  AST_DECEL_IGN: assert property (control.infinite_accel |->
      control.ramp_decel == control.ramp_accel) else $error("decel not ignored");
  AST_FLOOR_TOP: assert property (!speed_floor[12]) else $error("floor bit 12 set");
  AST_FLOOR_HELD: assert property (s_wr(5'h08) ##0 run |=>
      $stable(speed_floor)) else $error("floor changed while running");
  AST_MARK_WR: assert property (s_wr(5'h03) |=>
      marked_position == $past(access.wdata)) else $error("mark not stored");
  AST_DECAY_WR: assert property (s_wr(5'h0e) ##0 !refused |-> ##2
      {control.max_fast_decay_time, control.max_fall_step_time} == $past(access.wdata[7:0], 2))
      else $error("decay fields wrong");
endmodule

bind mpr_regs mpr_regs_chk u_chk (
  .sys_clk(sys_clk), .reset(reset), .access(access), .rdata(rdata), .motion(motion),
  .outputs_hiz(outputs_hiz), .control(control), .marked_position(marked_position),
  .speed_floor(speed_floor)
);

// ---- testbench/mpr_host.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Host side register access
// ****************************************************************
module mpr_host (
  input  wire logic                 sys_clk,
  output mpr_pkg::mpr_access_t      access,
  input  wire logic [21:0]          rdata
);
  initial access = '0;
  task automatic wr(input logic [4:0] a, input logic [21:0] d);
    @(negedge sys_clk);
    access <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    access <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [21:0] d);
    @(negedge sys_clk);
    access <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 22'h000000};
    @(negedge sys_clk);
    access <= '0;
    d = rdata;
  endtask
endmodule

// ---- testbench/motion_profile_param_regs_test.sv ----
`timescale 1ns/1ps

module motion_profile_param_regs_test;
  logic                  sys_clk = 1'b0;
  logic                  reset = 1'b1;
  mpr_pkg::mpr_access_t  access;
  mpr_pkg::mpr_motion_t  motion = mpr_pkg::MPR_STOPPED;
  mpr_pkg::mpr_control_t control;
  logic                  outputs_hiz = 1'b1;
  logic [19:0]           speed_in = 20'h00000;
  logic                  electrical_position_advance = 1'b0;
  logic [8:0]            electrical_position_next = 9'h000;
  logic [21:0]           rdata;
  logic [21:0]           marked_position;
  logic [21:0]           rv;
  logic [9:0]            speed_ceiling;
  logic [12:0]           speed_floor;
  int                    mismatches = 0;
  int                    cmp_count = 0;

  always #12.5 sys_clk = ~sys_clk;

  mpr_host u_host (.sys_clk(sys_clk), .access(access), .rdata(rdata));
  mpr_regs DUT (
    .sys_clk(sys_clk), .reset(reset), .access(access), .rdata(rdata), .motion(motion),
    .outputs_hiz(outputs_hiz), .speed_in(speed_in), .electrical_position_advance(electrical_position_advance),
    .electrical_position_next(electrical_position_next), .status_other(7'h55), .control(control),
    .marked_position(marked_position), .speed_ceiling(speed_ceiling), .speed_floor(speed_floor)
  );

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [21:0] exp);
    u_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic test_reset();
    rchk(mpr_pkg::ADDR_ACCEL_RATE, 22'h00008a);
    rchk(mpr_pkg::ADDR_SPEED_CEILING, 22'h000041);
    rchk(mpr_pkg::ADDR_FULLSTEP_THRESHOLD, 22'h000027);
    rchk(mpr_pkg::ADDR_DECEL_CURRENT, 22'h000029);
    rchk(5'h0d, 22'h000000);
    $display("test_reset done");
  endtask

  task automatic test_refuse();
    logic [4:0]  ad [7];
    logic [21:0] ex [7];
    ad = '{5'h02, 5'h05, 5'h06, 5'h08, 5'h0e, 5'h0f, 5'h04};
    ex = '{22'h0, 22'h8a, 22'h8a, 22'h0, 22'h19, 22'h29, 22'h0};
    motion <= mpr_pkg::MPR_CONST;
    for (int i = 0; i < 7; i++) begin
      u_host.wr(ad[i], 22'h000155);
      rchk(ad[i], ex[i]);
      rchk(mpr_pkg::ADDR_STATUS, 22'h0000d5);
      rchk(mpr_pkg::ADDR_STATUS, 22'h000055);
    end
    $display("test_refuse done");
  endtask

  task automatic test_stopped();
    motion <= mpr_pkg::MPR_STOPPED;
    outputs_hiz <= 1'b0;
    u_host.wr(mpr_pkg::ADDR_MIN_ON_TIME, 22'h00007f);
    rchk(mpr_pkg::ADDR_MIN_ON_TIME, 22'h000029);
    rchk(mpr_pkg::ADDR_STATUS, 22'h0000d5);
    outputs_hiz <= 1'b1;
    u_host.wr(mpr_pkg::ADDR_CURRENT_SPEED, 22'h000123);
    rchk(mpr_pkg::ADDR_STATUS, 22'h0000d5);
    u_host.wr(mpr_pkg::ADDR_MIN_ON_TIME, 22'h00007f);
    u_host.wr(mpr_pkg::ADDR_DECAY_FALL_TIMES, 22'h0000a5);
    settle(1);
    chk(control.min_on_time, 22'h00007f);
    chk({control.max_fast_decay_time, control.max_fall_step_time}, 22'h0000a5);
    u_host.wr(mpr_pkg::ADDR_ACCEL_RATE, 22'h000fff);
    // Microstep bits already masked to the step mode
    u_host.wr(mpr_pkg::ADDR_ELECTRICAL_POSITION, 22'h000180);
    settle(1);
    chk(control.infinite_accel, 22'h000001);
    chk(control.ramp_decel, 22'h000fff);
    chk(control.electrical_position, 22'h000180);
    // Engine advance loads the next position
    electrical_position_next <= 9'h0a5;
    electrical_position_advance <= 1'b1;
    settle(1);
    electrical_position_advance <= 1'b0;
    settle(1);
    chk(control.electrical_position, 22'h0000a5);
    // Host write beats a simultaneous advance
    electrical_position_advance <= 1'b1;
    u_host.wr(mpr_pkg::ADDR_ELECTRICAL_POSITION, 22'h000100);
    electrical_position_advance <= 1'b0;
    settle(1);
    chk(control.electrical_position, 22'h000100);
    u_host.wr(mpr_pkg::ADDR_MARKED_POSITION, 22'h200000);
    rchk(mpr_pkg::ADDR_MARKED_POSITION, 22'h200000);
    chk(marked_position, 22'h200000);
    u_host.wr(mpr_pkg::ADDR_SPEED_CEILING, 22'h0003ff);
    rchk(mpr_pkg::ADDR_SPEED_CEILING, 22'h0003ff);
    chk(speed_ceiling, 22'h0003ff);
    u_host.wr(mpr_pkg::ADDR_SPEED_FLOOR, 22'h001fff);
    rchk(mpr_pkg::ADDR_SPEED_FLOOR, 22'h000fff);
    $display("test_stopped done");
  endtask

  task automatic test_torque();
    mpr_pkg::mpr_motion_t mo [4];
    logic [21:0]          ex [4];
    mo = '{mpr_pkg::MPR_ACCEL, mpr_pkg::MPR_CONST, mpr_pkg::MPR_DECEL, mpr_pkg::MPR_STOPPED};
    ex = '{22'h11, 22'h7f, 22'h22, 22'h00};
    u_host.wr(mpr_pkg::ADDR_HOLD_CURRENT, 22'h000000);
    u_host.wr(mpr_pkg::ADDR_RUN_CURRENT, 22'h00007f);
    u_host.wr(mpr_pkg::ADDR_ACCEL_CURRENT, 22'h000011);
    u_host.wr(mpr_pkg::ADDR_DECEL_CURRENT, 22'h000022);
    for (int i = 0; i < 4; i++) begin
      motion <= mo[i];
      settle(2);
      chk(control.torque_level, ex[i]);
    end
    $display("test_torque done");
  endtask

  task automatic test_fullstep();
    u_host.wr(mpr_pkg::ADDR_FULLSTEP_THRESHOLD, 22'h000000);
    speed_in <= 20'h00201;
    settle(3);
    chk(control.fullstep_active, 22'h000001);
    rchk(mpr_pkg::ADDR_CURRENT_SPEED, 22'h000201);
    speed_in <= 20'h00200;
    settle(3);
    chk(control.fullstep_active, 22'h000000);
    u_host.wr(mpr_pkg::ADDR_FULLSTEP_THRESHOLD, 22'h0000ff);
    speed_in <= 20'hfffff;
    settle(3);
    chk(control.fullstep_active, 22'h000000);
    $display("test_fullstep done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    settle(10);
    reset <= 1'b0;
    test_reset();
    test_refuse();
    test_stopped();
    test_torque();
    test_fullstep();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
endmodule
